// ### shared/apc_pkg.sv
/*
  Shared constants and types of the row protocol layer: register map,
  reset values, checksum settings, latency figures, sync words, carriers.
  Assumes every user writes apc_pkg::name; nothing is imported.
*/
package apc_pkg;
  localparam int NCH    = 32; // serial data channels, one per converter pair
  localparam int ADC_W  = 9;
  localparam int PIX_W  = 8;
  localparam int ADDR_W = 11;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [6:0] REG_TRIM = 7'h40;
  localparam logic [6:0] REG_PD_A = 7'h42;
  localparam logic [6:0] REG_PD_B = 7'h43;
  localparam logic [6:0] REG_PD_C = 7'h44;
  localparam logic [6:0] REG_PD_D = 7'h45;
  localparam logic [6:0] REG_PD_E = 7'h46;
  localparam logic [6:0] REG_CRC  = 7'h47;
  localparam int TRIM_LSB = 4;
  localparam int TRIM_MSB = 6;
  localparam int CRC_DATA_BIT = 0;
  localparam int CRC_SYNC_BIT = 1;
  localparam logic [2:0]  TRIM_RST     = 3'h7;
  localparam logic [39:0] PD_RST       = 40'h00_0000_0000;
  localparam logic [1:0]  CRC_CTRL_RST = 2'h1;
  localparam int SPI_LEN = 16;

  // ****************************************
  // checksum and latency
  // ****************************************
  localparam logic [7:0] CRC_POLY   = 8'h4D;
  localparam logic [7:0] CRC_PRESET = 8'hFF;
  localparam int CONV_DIV     = 8; // converter clock = master / 8
  localparam int ADC_LAT_CONV = 4; // converter periods, sample to result
  localparam int AFE_LAT_HALF = 3; // front end, in half converter periods
  localparam int FRONT_LAT = (ADC_LAT_CONV * 2 + AFE_LAT_HALF) * CONV_DIV / 2;

  // ****************************************
  // sync channel words and patterns
  // ****************************************
  localparam logic [7:0] FRAME_WORD         = 8'hF0;
  localparam logic [7:0] LINE_BEGIN_WORD    = 8'hA5;
  localparam logic [7:0] LINE_FINISH_WORD   = 8'h5A;
  localparam logic [7:0] FILLER_WORD_FIRST  = 8'h3C;
  localparam logic [7:0] FILLER_WORD_SECOND = 8'hC3;
  localparam logic [7:0] TRAIN_WORD         = 8'h96;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_TRAIN, MODE_TEST} apc_mode_e;
  typedef enum logic [1:0] {FIN_IDLE, FIN_DATA, FIN_SYNC} apc_fin_e;

  typedef struct packed {
    logic              frameBegin;
    logic              lineBegin;
    logic              lineFinish;
    logic [ADDR_W-1:0] lineAddr;
  } apc_seq_s;

  typedef struct packed {
    logic [NCH-1:0][PIX_W-1:0] pix;
    logic [PIX_W-1:0]          sync;
  } apc_slot_s;
endpackage

// ### hw/apc_fifo.sv
/*
  Word FIFO with valid/ready on both sides and a registered head word.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module apc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic      [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          head_r, head_nxt;
  logic [W-1:0]  outData_r;
  logic          push, load;

  // ****************************************
  // pointers and head register
  // ****************************************
  // head refills whenever it is empty or being taken
  always_comb begin
    push      = inValid && inReady;
    load      = (cnt_r != '0) && (!head_r || outReady);
    wrPtr_nxt = push ? wrPtr_r + AW'(1) : wrPtr_r;
    rdPtr_nxt = load ? rdPtr_r + AW'(1) : rdPtr_r;
    cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(load);
    head_nxt  = load || (head_r && !outReady);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r   <= '0;
      head_r  <= 1'b0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      cnt_r   <= cnt_nxt;
      head_r  <= head_nxt;
    end
  end

  // storage carries no reset, contents are qualified by the count
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
    if (load) begin
      outData_r <= mem[rdPtr_r];
    end
  end

  assign inReady  = cnt_r != (AW+1)'(DEPTH);
  assign outValid = head_r;
  assign outData  = outData_r;
endmodule

// ### hw/apc_crc8.sv
/*
  Eight-bit row checksum, one byte per enable, msb first.
  Assumes clr marks a row start and may coincide with the first byte.
*/
`timescale 1ns/1ns
module apc_crc8 (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [7:0] din,
  output logic      [7:0] crc
);
  logic [7:0] crc_r, crc_nxt;

  // bitwise divide; a table would be faster but this fits one cycle
  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] s;
    logic       fb;
    s = c;
    for (int i = 7; i >= 0; i--) begin
      fb = s[7] ^ d[i];
      s  = {s[6:0], 1'b0} ^ (fb ? apc_pkg::CRC_POLY : 8'h00);
    end
    return s;
  endfunction

  always_comb begin
    crc_nxt = clr ? apc_pkg::CRC_PRESET : crc_r;
    if (en) begin
      crc_nxt = crcStep(crc_nxt, din);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      crc_r <= apc_pkg::CRC_PRESET;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;

  crc_preset_a: assert property (
    @(posedge ref_clk) disable iff (srst) (clr && !en) |=> crc_r == apc_pkg::CRC_PRESET)
    else $error("checksum not preset at row start");
endmodule

// ### hw/apc_protocol_layer.sv
/*
  Protocol layer: truncates and pairs converter results, adds the row
  checksum, picks the readout mode, builds the sync channel and shifts
  every channel out msb first on the link clock, with a serial port for
  the configuration bytes.
  Assumes seqIn and the converter results are on ref_clk; spi pins and
  lnkClk come from outside and are synchronised here.
*/
`timescale 1ns/1ns
// How it works
// - each converter pair feeds exactly one of 32 serial channels
// - odd kernel word then even kernel word share the channel
// - nine-bit results lose their lsb, upper eight bits are sent
// - reference trim sits in bits 6:4 of register 0x40
// - trim code 000 is 0.5x, 111 is 1.0x and the reset value
// - converter result comes four converter periods after sampling
// - front end plus converter delay totals 44 master clocks
// - registers 0x42 to 0x46 power down pairs one bit each; only 0x42 to 0x45 drive the 32 channels, 0x46 is stored only
// - power-down bit one means off; all reset to zero
// - checksum restarts at every new row on every channel
// - checksum is crc-8 with x^8+x^6+x^3+x^2+1
// - checksum register presets to all ones
// - bit 0 of register 0x47 inserts data checksums, resets to one
// - bit 1 of register 0x47 adds sync checksum, resets to zero
// - normal, training and test-image readout modes
// - this block builds the sync channel stream
// - each word is shifted out msb first
// - sync carries frame, line begin/finish, two fillers, line address
// - sync words are delayed by the front end latency
module apc_protocol_layer #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                                  ref_clk,
  input  wire logic                                  srst,
  input  wire logic                                  spiClk,
  input  wire logic                                  spiCsN,
  input  wire logic                                  spiMosi,
  output logic                                       spiMiso,
  input  wire apc_pkg::apc_seq_s                     seqIn,
  input  wire apc_pkg::apc_mode_e                    readMode,
  input  wire logic                                  adcValid,
  input  wire logic [apc_pkg::NCH-1:0][apc_pkg::ADC_W-1:0] adcOdd,
  input  wire logic [apc_pkg::NCH-1:0][apc_pkg::ADC_W-1:0] adcEven,
  output logic                                       inReady,
  output logic      [2:0]                            adcRefTrim,
  output logic      [apc_pkg::NCH-1:0]               chanPowerDown,
  input  wire logic                                  lnkClk,
  output logic      [apc_pkg::NCH-1:0]               serData,
  output logic                                       serSync
);
  localparam int NCH = apc_pkg::NCH;
  localparam int LAT = apc_pkg::FRONT_LAT;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] spiClkSy_r, lnkSy_r;
  logic [1:0] spiCsSy_r, spiMosiSy_r;
  logic       spiRise, spiFall, spiIdle, lnkRise;

  // stage 0 feeds stage 1 only; edges come from stages 1 and 2
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      spiClkSy_r  <= 3'h0;
      spiCsSy_r   <= 2'h3;
      spiMosiSy_r <= 2'h0;
      lnkSy_r     <= 3'h0;
    end else begin
      spiClkSy_r  <= {spiClkSy_r[1:0], spiClk};
      spiCsSy_r   <= {spiCsSy_r[0], spiCsN};
      spiMosiSy_r <= {spiMosiSy_r[0], spiMosi};
      lnkSy_r     <= {lnkSy_r[1:0], lnkClk};
    end
  end
  assign spiRise = spiClkSy_r[1] && !spiClkSy_r[2];
  assign spiFall = !spiClkSy_r[1] && spiClkSy_r[2];
  assign spiIdle = spiCsSy_r[1];
  assign lnkRise = lnkSy_r[1] && !lnkSy_r[2];

  // ****************************************
  // serial port and configuration registers
  // ****************************************
  logic [4:0]  spiCnt_r, spiCnt_nxt;
  logic [15:0] spiSh_r, spiSh_nxt;
  logic [7:0]  txSh_r, txSh_nxt;
  logic        miso_r, miso_nxt;
  logic [2:0]  trim_r, trim_nxt;
  logic [39:0] pd_r, pd_nxt;
  logic [1:0]  crcCtl_r, crcCtl_nxt;

  // unmapped addresses read zero; trim bits outside 6:4 read zero
  function automatic logic [7:0] regRead(input logic [6:0] a);
    unique case (a)
      apc_pkg::REG_TRIM: regRead = {1'b0, trim_r, 4'h0};
      apc_pkg::REG_PD_A: regRead = pd_r[7:0];
      apc_pkg::REG_PD_B: regRead = pd_r[15:8];
      apc_pkg::REG_PD_C: regRead = pd_r[23:16];
      apc_pkg::REG_PD_D: regRead = pd_r[31:24];
      apc_pkg::REG_PD_E: regRead = pd_r[39:32];
      apc_pkg::REG_CRC:  regRead = {6'h00, crcCtl_r};
      default:           regRead = 8'h00;
    endcase
  endfunction

  // frame: write flag, 7-bit address, data byte, all msb first
  always_comb begin
    spiCnt_nxt = spiCnt_r;
    spiSh_nxt  = spiSh_r;
    txSh_nxt   = txSh_r;
    miso_nxt   = miso_r;
    trim_nxt   = trim_r;
    pd_nxt     = pd_r;
    crcCtl_nxt = crcCtl_r;
    if (spiIdle) begin
      spiCnt_nxt = 5'h00;
    end else if (spiRise) begin
      spiSh_nxt  = {spiSh_r[14:0], spiMosiSy_r[1]};
      spiCnt_nxt = spiCnt_r + 5'h01;
      if (spiCnt_r == 5'h07) begin
        txSh_nxt = regRead(spiSh_nxt[6:0]);
      end
      if (spiCnt_r == 5'(apc_pkg::SPI_LEN - 1) && spiSh_nxt[15]) begin
        unique case (spiSh_nxt[14:8])
          apc_pkg::REG_TRIM: trim_nxt = spiSh_nxt[apc_pkg::TRIM_MSB:apc_pkg::TRIM_LSB];
          apc_pkg::REG_PD_A: pd_nxt[7:0]   = spiSh_nxt[7:0];
          apc_pkg::REG_PD_B: pd_nxt[15:8]  = spiSh_nxt[7:0];
          apc_pkg::REG_PD_C: pd_nxt[23:16] = spiSh_nxt[7:0];
          apc_pkg::REG_PD_D: pd_nxt[31:24] = spiSh_nxt[7:0];
          apc_pkg::REG_PD_E: pd_nxt[39:32] = spiSh_nxt[7:0];
          apc_pkg::REG_CRC:  crcCtl_nxt = spiSh_nxt[1:0];
          default:           crcCtl_nxt = crcCtl_r;
        endcase
      end
    end else if (spiFall) begin
      miso_nxt = txSh_r[7];
      txSh_nxt = {txSh_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      spiCnt_r <= 5'h00;
      spiSh_r  <= 16'h0000;
      txSh_r   <= 8'h00;
      miso_r   <= 1'b0;
      trim_r   <= apc_pkg::TRIM_RST;
      pd_r     <= apc_pkg::PD_RST;
      crcCtl_r <= apc_pkg::CRC_CTRL_RST;
    end else begin
      spiCnt_r <= spiCnt_nxt;
      spiSh_r  <= spiSh_nxt;
      txSh_r   <= txSh_nxt;
      miso_r   <= miso_nxt;
      trim_r   <= trim_nxt;
      pd_r     <= pd_nxt;
      crcCtl_r <= crcCtl_nxt;
    end
  end
  assign spiMiso       = miso_r;
  assign adcRefTrim    = trim_r;
  assign chanPowerDown = pd_r[NCH-1:0];

  // ****************************************
  // sequencer events, front end latency
  // ****************************************
  apc_pkg::apc_seq_s seqDly_r [LAT];
  apc_pkg::apc_seq_s seqLate;

  // sync events wait out the front end
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < LAT; i++) begin
      if (srst) begin
        seqDly_r[i] <= '0;
      end else begin
        seqDly_r[i] <= (i == 0) ? seqIn : seqDly_r[(i == 0) ? 0 : i - 1];
      end
    end
  end
  assign seqLate = seqDly_r[LAT-1];

  // ****************************************
  // slot builder: pairing, checksum, sync words
  // ****************************************
  logic [NCH-1:0][7:0] evenHold_r, evenHold_nxt, pixOdd, pixEven;
  logic                 evenPend_r, evenPend_nxt;
  apc_pkg::apc_fin_e    fin_r, fin_nxt;
  logic [1:0]           slotCnt_r, slotCnt_nxt;
  logic [7:0]           testCnt_r, testCnt_nxt;
  logic                 frame_r, frame_nxt;
  logic [apc_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [NCH:0][7:0]    crcVal, crcDin;
  logic [7:0]           syncWord;
  logic                 wrValid, crcFeed;
  apc_pkg::apc_slot_s   wrSlot;

  function automatic logic [7:0] pixSel(input logic [8:0] raw, input logic [7:0] idx);
    unique case (readMode)
      apc_pkg::MODE_NORMAL: pixSel = raw[8:1];
      apc_pkg::MODE_TRAIN:  pixSel = apc_pkg::TRAIN_WORD;
      apc_pkg::MODE_TEST:   pixSel = testCnt_r + idx;
      default:              pixSel = 8'h00;
    endcase
  endfunction

  for (genvar c = 0; c < NCH; c++) begin : g_pix
    assign pixOdd[c]  = pixSel(adcOdd[c], 8'(c));
    assign pixEven[c] = pixSel(adcEven[c], 8'(c + NCH));
  end

  // word on sync per slot of the row
  always_comb begin
    unique case (slotCnt_r)
      2'h0: syncWord = frame_r ? apc_pkg::FRAME_WORD : apc_pkg::LINE_BEGIN_WORD;
      2'h1: syncWord = addr_r[7:0];
      2'h2: syncWord = 8'(addr_r[apc_pkg::ADDR_W-1:8]);
      2'h3: syncWord = apc_pkg::FILLER_WORD_FIRST;
    endcase
  end

  // even word of a pair waits one cycle; row end then adds checksum slots
  always_comb begin
    evenHold_nxt = evenHold_r;
    evenPend_nxt = evenPend_r;
    fin_nxt      = fin_r;
    slotCnt_nxt  = slotCnt_r;
    testCnt_nxt  = testCnt_r;
    frame_nxt    = frame_r;
    addr_nxt     = addr_r;
    wrValid      = 1'b0;
    crcFeed      = 1'b0;
    wrSlot       = '0;
    if (seqLate.lineBegin) begin
      slotCnt_nxt = 2'h0;
      testCnt_nxt = 8'h00;
      frame_nxt   = seqLate.frameBegin;
      addr_nxt    = seqLate.lineAddr;
    end
    if (seqLate.lineFinish) begin
      fin_nxt = apc_pkg::FIN_DATA;
    end
    if (evenPend_r) begin
      wrValid      = 1'b1;
      crcFeed      = 1'b1;
      evenPend_nxt = 1'b0;
      wrSlot.pix   = evenHold_r;
      wrSlot.sync  = syncWord;
      slotCnt_nxt  = (slotCnt_r == 2'h3) ? 2'h3 : slotCnt_r + 2'h1;
    end else if (adcValid) begin
      wrValid      = 1'b1;
      crcFeed      = 1'b1;
      evenPend_nxt = 1'b1;
      evenHold_nxt = pixEven;
      wrSlot.pix   = pixOdd;
      wrSlot.sync  = syncWord;
      slotCnt_nxt  = (slotCnt_r == 2'h3) ? 2'h3 : slotCnt_r + 2'h1;
      testCnt_nxt  = testCnt_r + 8'h01;
    end else if (fin_r == apc_pkg::FIN_DATA) begin
      wrValid     = 1'b1;
      wrSlot.pix  = crcCtl_r[apc_pkg::CRC_DATA_BIT] ? crcVal[NCH-1:0] : '0;
      wrSlot.sync = apc_pkg::LINE_FINISH_WORD;
      fin_nxt     = crcCtl_r[apc_pkg::CRC_SYNC_BIT] ? apc_pkg::FIN_SYNC : apc_pkg::FIN_IDLE;
    end else if (fin_r == apc_pkg::FIN_SYNC) begin
      wrValid     = 1'b1;
      wrSlot.sync = crcVal[NCH];
      fin_nxt     = apc_pkg::FIN_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evenHold_r <= '0;
      evenPend_r <= 1'b0;
      fin_r      <= apc_pkg::FIN_IDLE;
      slotCnt_r  <= 2'h0;
      testCnt_r  <= 8'h00;
      frame_r    <= 1'b0;
      addr_r     <= '0;
    end else begin
      evenHold_r <= evenHold_nxt;
      evenPend_r <= evenPend_nxt;
      fin_r      <= fin_nxt;
      slotCnt_r  <= slotCnt_nxt;
      testCnt_r  <= testCnt_nxt;
      frame_r    <= frame_nxt;
      addr_r     <= addr_nxt;
    end
  end

  // one checksum per data channel plus one for sync
  assign crcDin = {wrSlot.sync, wrSlot.pix};
  for (genvar c = 0; c <= NCH; c++) begin : g_crc
    apc_crc8 u_crc (
      .ref_clk (ref_clk),
      .srst    (srst),
      .clr     (seqLate.lineBegin),
      .en      (crcFeed),
      .din     (crcDin[c]),
      .crc     (crcVal[c])
    );
  end

  // ****************************************
  // slot buffer and serialisers
  // ****************************************
  apc_pkg::apc_slot_s   fifoOut;
  logic                 fifoValid, popNow, idleSel_r, idleSel_nxt;
  logic [2:0]           serCnt_r, serCnt_nxt;
  logic [NCH-1:0][7:0]  shPix_r, shPix_nxt;
  logic [7:0]           shSync_r, shSync_nxt;

  // words arriving while full are lost; inReady warns the sequencer
  apc_fifo #(
    .W     ($bits(apc_pkg::apc_slot_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .inValid  (wrValid),
    .inReady  (inReady),
    .inData   (wrSlot),
    .outValid (fifoValid),
    .outReady (popNow),
    .outData  (fifoOut)
  );

  assign popNow = lnkRise && (serCnt_r == 3'h0);

  // load every eighth link edge, then shift msb first
  always_comb begin
    serCnt_nxt  = serCnt_r;
    shPix_nxt   = shPix_r;
    shSync_nxt  = shSync_r;
    idleSel_nxt = idleSel_r;
    if (lnkRise) begin
      serCnt_nxt = serCnt_r + 3'h1;
      if (serCnt_r == 3'h0) begin
        if (fifoValid) begin
          shPix_nxt  = fifoOut.pix;
          shSync_nxt = fifoOut.sync;
        end else begin
          shPix_nxt   = '0;
          shSync_nxt  = idleSel_r ? apc_pkg::FILLER_WORD_SECOND : apc_pkg::FILLER_WORD_FIRST;
          idleSel_nxt = !idleSel_r;
        end
        for (int c = 0; c < NCH; c++) begin
          if (pd_r[c]) begin
            shPix_nxt[c] = 8'h00;
          end
        end
      end else begin
        for (int c = 0; c < NCH; c++) begin
          shPix_nxt[c] = {shPix_r[c][6:0], 1'b0};
        end
        shSync_nxt = {shSync_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serCnt_r  <= 3'h0;
      shPix_r   <= '0;
      shSync_r  <= 8'h00;
      idleSel_r <= 1'b0;
    end else begin
      serCnt_r  <= serCnt_nxt;
      shPix_r   <= shPix_nxt;
      shSync_r  <= shSync_nxt;
      idleSel_r <= idleSel_nxt;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_out
    assign serData[c] = shPix_r[c][7];
  end
  assign serSync = shSync_r[7];

  // ****************************************
  // checks
  // ****************************************
  logic [5:0] rstAge_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rstAge_r <= 6'h00;
    end else if (rstAge_r != 6'h3F) begin
      rstAge_r <= rstAge_r + 6'h01;
    end
  end

  trim_reset_a: assert property (
    @(posedge ref_clk) disable iff (srst) $past(srst) |-> adcRefTrim == 3'h7)
    else $error("trim not at 1.0x after reset");
  pd_reset_a: assert property (
    @(posedge ref_clk) disable iff (srst) $past(srst) |-> pd_r == 40'h00_0000_0000)
    else $error("channels not powered on after reset");
  crc_ctl_reset_a: assert property (
    @(posedge ref_clk) disable iff (srst) $past(srst) |-> crcCtl_r == 2'h1)
    else $error("checksum control reset value wrong");
  sync_delay_a: assert property (
    @(posedge ref_clk) disable iff (srst) (rstAge_r > 6'h2D) |-> seqLate == $past(seqIn, 44))
    else $error("sync events not delayed by 44 clocks");
  odd_even_mux_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (adcValid && !evenPend_r && readMode == apc_pkg::MODE_NORMAL)
      |=> wrValid && wrSlot.pix[0] == $past(adcEven[0][8:1]))
    else $error("even word did not follow odd word");
  pixel_trunc_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (adcValid && !evenPend_r && readMode == apc_pkg::MODE_NORMAL)
      |-> wrValid && wrSlot.pix[NCH-1] == adcOdd[NCH-1][8:1])
    else $error("pixel not upper eight bits");
  crc_insert_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (fin_r == apc_pkg::FIN_DATA && crcCtl_r[0] && !evenPend_r && !adcValid)
      |-> wrValid && wrSlot.pix[0] == crcVal[0] && wrSlot.sync == 8'h5A)
    else $error("checksum slot missing after row");
  msb_first_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (lnkRise && serCnt_r != 3'h0) |=> shPix_r[0] == {$past(shPix_r[0][6:0]), 1'b0})
    else $error("word not shifted msb first");
  pd_mute_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (popNow && pd_r[1]) |=> (serData[1] == 1'b0) [*8])
    else $error("powered-down channel still sends");
endmodule

// ### testbench/apc_rx_model.sv
/* Receiver model: recovers channel 0 and sync bytes, rechecks row crc.
   Assumes a free-running link clock; bits are taken on its falling edge. */
`timescale 1ns/1ns
module apc_rx_model (
  input  wire logic       lnkClk,
  input  wire logic       lane,
  input  wire logic       syncLane,
  output logic            rxStrobe,
  output logic      [7:0] rxByte,
  output logic            rxBad,
  output logic            rxSyncOk
);
  logic [7:0] dSh, sSh, crc, sCrc;
  int         bitCnt = -1;
  logic       inRow  = 0;
  logic       afterRow = 0;
  initial {rxStrobe, rxByte, rxBad, rxSyncOk} = '0;
  // msb first, lock on line begin word
  always @(negedge lnkClk) begin
    dSh = {dSh[6:0], lane};
    sSh = {sSh[6:0], syncLane};
    rxStrobe <= 0;
    if (bitCnt < 0 && sSh === apc_pkg::LINE_BEGIN_WORD) bitCnt = 8;
    if (bitCnt == 8) begin
      bitCnt = 0;
      // word after the finish carries the sync checksum
      if (afterRow) rxSyncOk <= (sSh === sCrc);
      afterRow = 0;
      if (sSh === apc_pkg::LINE_BEGIN_WORD) begin
        inRow = 1;
        crc = apc_pkg::CRC_PRESET;
        sCrc = apc_pkg::CRC_PRESET;
      end
      if (inRow) begin
        rxStrobe <= 1;
        rxByte   <= dSh;
        if (sSh === apc_pkg::LINE_FINISH_WORD) begin
          inRow = 0;
          afterRow = 1;
          rxBad <= (dSh !== crc);
        end else begin
          for (int i = 7; i >= 0; i--) begin
            crc = {crc[6:0], 1'b0} ^ (crc[7] ^ dSh[i] ? apc_pkg::CRC_POLY : 8'h00);
            sCrc = {sCrc[6:0], 1'b0} ^ (sCrc[7] ^ sSh[i] ? apc_pkg::CRC_POLY : 8'h00);
          end
        end
      end
    end
    if (bitCnt >= 0) bitCnt++;
  end
endmodule

// ### testbench/tb_apc_protocol_layer.sv
/* Bench: registers over the serial port, rows on channel 0, buffer fill.
   Assumes the receiver model decodes the link. */
`timescale 1ns/1ns
module tb_apc_protocol_layer;
  logic ref_clk = 0, srst = 1, spiClk = 0, spiCsN = 1, spiMosi = 0, adcValid = 0, lnkClk = 0;
  logic spiMiso, inReady, serSync, rxStrobe, rxBad, rxSyncOk, full;
  logic [2:0] adcRefTrim;
  logic [31:0] chanPowerDown, serData;
  logic [7:0] rxByte, rd, d, expQ[$];
  logic [287:0] adcOdd = '0, adcEven = '0;
  apc_pkg::apc_seq_s seqIn = '0;
  apc_pkg::apc_mode_e readMode = apc_pkg::MODE_NORMAL;
  int err_count = 0, total_checks = 0, seed = 78, cyc = 0;
  always #10 ref_clk = ~ref_clk;
  // link clock offset so its edges never meet ref_clk edges
  initial #7 forever #80 lnkClk = ~lnkClk;
  apc_protocol_layer dut (.ref_clk(ref_clk), .srst(srst), .spiClk(spiClk), .spiCsN(spiCsN),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .seqIn(seqIn), .readMode(readMode),
    .adcValid(adcValid), .adcOdd(adcOdd), .adcEven(adcEven), .inReady(inReady),
    .adcRefTrim(adcRefTrim), .chanPowerDown(chanPowerDown), .lnkClk(lnkClk),
    .serData(serData), .serSync(serSync));
  apc_rx_model rx (.lnkClk(lnkClk), .lane(serData[0]), .syncLane(serSync),
    .rxStrobe(rxStrobe), .rxByte(rxByte), .rxBad(rxBad), .rxSyncOk(rxSyncOk));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] step(logic [7:0] c, logic [7:0] x);
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ (c[7] ^ x[i] ? 8'h4D : 8'h00);
    return c;
  endfunction
  // one 16-bit frame; half period of 6 clocks so the sync stage keeps up
  task automatic spi(input logic w, input logic [6:0] a, input logic [7:0] v,
                     output logic [7:0] q);
    logic [15:0] f;
    f = {w, a, v};
    @(posedge ref_clk) spiCsN <= 0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge ref_clk) spiMosi <= f[i];
      repeat (5) @(posedge ref_clk);
      if (i < 8) q[i] = spiMiso;
      spiClk <= 1;
      repeat (6) @(posedge ref_clk);
      spiClk <= 0;
    end
    repeat (6) @(posedge ref_clk);
    spiCsN <= 1;
    repeat (6) @(posedge ref_clk);
  endtask
  // one row of n converter pairs, then the finish slot
  task automatic row(input int n, input logic en);
    logic [287:0] vo, ve;
    logic [7:0] c, po, pe;
    c = apc_pkg::CRC_PRESET;
    // low address byte kept off the begin and finish sync words
    @(posedge ref_clk) begin
      seqIn.lineBegin <= 1;
      seqIn.lineAddr <= 11'($random(seed)) | 11'h0C0;
    end
    @(posedge ref_clk) seqIn.lineBegin <= 0;
    repeat (50) @(posedge ref_clk);
    for (int k = 0; k < n; k++) begin
      vo = {9{$random(seed)}};
      ve = {9{$random(seed)}};
      @(posedge ref_clk) begin
        adcValid <= 1;
        adcOdd <= vo;
        adcEven <= ve;
      end
      @(posedge ref_clk) adcValid <= 0;
      @(posedge ref_clk);
      po = readMode == apc_pkg::MODE_TRAIN ? apc_pkg::TRAIN_WORD :
           readMode == apc_pkg::MODE_TEST ? 8'(k) : vo[8:1];
      pe = readMode == apc_pkg::MODE_TRAIN ? apc_pkg::TRAIN_WORD :
           readMode == apc_pkg::MODE_TEST ? 8'(k + 32) : ve[8:1];
      expQ.push_back(po);
      expQ.push_back(pe);
      c = step(step(c, po), pe);
    end
    @(posedge ref_clk) seqIn.lineFinish <= 1;
    @(posedge ref_clk) seqIn.lineFinish <= 0;
    expQ.push_back(en ? c : 8'h00);
    repeat (1500) @(posedge ref_clk);
    check({7'h00, rxBad}, {7'h00, !en});
  endtask
  // oldest note against each recovered byte
  always @(posedge rxStrobe) begin
    #1;
    if (expQ.size() == 0) check(8'h00, 8'h01);
    else check(rxByte, expQ.pop_front());
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 0;
    repeat (5) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      spi(0, 7'h40 + 7'(i), 8'h00, rd);
      check(rd, i == 0 ? 8'h70 : i == 7 ? 8'h01 : 8'h00);
    end
    for (int t = 0; t < 8; t++) begin
      spi(1, 7'h40, {1'b0, 3'(t), 4'h0}, rd);
      check({5'h00, adcRefTrim}, 8'(t));
    end
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      spi(1, 7'h42 + 7'(i), d, rd);
      spi(0, 7'h42 + 7'(i), 8'h00, rd);
      check(rd, d);
      check(chanPowerDown[8*i+:8], d);
    end
    spi(1, 7'h42, 8'h00, rd);
    row(4, 1);
    row(6, 1);
    spi(1, 7'h47, 8'h00, rd);
    row(3, 0);
    spi(1, 7'h47, 8'h03, rd);
    for (int m = 0; m < 3; m++) begin
      readMode <= apc_pkg::apc_mode_e'(m);
      row(2, 1);
      check({7'h00, rxSyncOk}, 8'h01);
    end
    // overfill the buffer while modes change, then let it drain
    full = 0;
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk) begin
        adcValid <= 1;
        readMode <= apc_pkg::apc_mode_e'(k % 3);
      end
      @(posedge ref_clk) adcValid <= 0;
      #1;
      if (inReady === 1'b0) full = 1;
    end
    check({7'h00, full}, 8'h01);
    repeat (3000) @(posedge ref_clk);
    check({7'h00, inReady}, 8'h01);
    check(8'(expQ.size()), 8'h00);
    wrap_up();
  end
endmodule
